// ---- verilog/pwm_dac_pkg.sv ----
// shared constants and types for the pulse-width/rate-multiplier dac
package pwm_dac_pkg;
  localparam int          NUM_CH       = 4;
  localparam int          CNT_W        = 10;
  localparam int          LOW_W        = 6;
  // register word offsets (byte address = 4 * index)
  localparam logic [2:0]  IDX_WEIGHT0  = 3'h0;
  localparam logic [2:0]  IDX_RATE10   = 3'h1;
  localparam logic [2:0]  IDX_WEIGHT1  = 3'h2;
  localparam logic [2:0]  IDX_WEIGHT2  = 3'h3;
  localparam logic [2:0]  IDX_RATE32   = 3'h4;
  localparam logic [2:0]  IDX_WEIGHT3  = 3'h5;
  localparam logic [2:0]  IDX_COUNT    = 3'h6;
  // field positions inside a weight register
  localparam int          INV_BIT      = 6;
  localparam int          RSV_BIT      = 7;
  localparam logic [7:0]  WEIGHT_RST   = 8'h80;
  localparam logic [7:0]  RATE_RST     = 8'h00;

  typedef struct packed {
    logic [5:0] weight;
    logic       output_invert;
  } chan_cfg_s;

  typedef struct packed {
    logic [CNT_W-1:0]    count;
    chan_cfg_s [3:0]     cfg;
    logic [3:0][3:0]     rate_multiplier;
    logic [3:0]          pulse;
    logic [3:0]          pin;
    logic                ack;
    logic [31:0]         rdata;
  } state_s;
endpackage : pwm_dac_pkg

// ---- verilog/pwm_rate_multiplier_dac.sv ----
// four-channel 10-bit pulse-width dac with rate multiplier, wishbone slave
`timescale 1ns/100ps
module pwm_rate_multiplier_dac (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [3:0]  dac_out
);
  pwm_dac_pkg::state_s st;
  pwm_dac_pkg::state_s next_st;

  logic [5:0] low_cnt;
  logic [3:0] period;
  logic [3:0] extend;
  logic       req;
  logic       wr;
  logic [2:0] idx;

  assign low_cnt = st.count[5:0];
  assign period  = st.count[9:6];
  assign req     = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign idx     = wb_adr_i[4:2];

  // per-channel decode of which periods take the extra clock
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ext
      logic [3:0] r;
      assign r = st.rate_multiplier[g];
      // one-hot weights add; period 0 never matches
      assign extend[g] = (r[0] & (period == 4'h8))
                       | (r[1] & (period[2:0] == 3'h4))
                       | (r[2] & (period[1:0] == 2'h2))
                       | (r[3] & period[0]);
    end
  endgenerate

  // next state: counter, pulse generation, register file, bus answer
  always_comb begin
    next_st = st;
    next_st.count = st.count + 10'h001;
    for (int i = 0; i < 4; i++) begin
      // pulse is registered, so each branch decides the next slot's level
      if (low_cnt == 6'h3E) begin
        // extra clock in the last slot, just ahead of the wrap
        next_st.pulse[i] = extend[i];
      end else if (low_cnt == 6'h3F) begin
        // wrap starts the pulse; zero weight never does
        next_st.pulse[i] = (st.cfg[i].weight != 6'h00);
      end else if (low_cnt + 6'h01 == st.cfg[i].weight) begin
        // counter reaching the weight ends the pulse
        next_st.pulse[i] = 1'b0;
      end
      // polarity swap; invert of idle gives constant high
      next_st.pin[i] = next_st.pulse[i] ^ st.cfg[i].output_invert;
    end
    next_st.ack = req;
    next_st.rdata = 32'h0000_0000;
    if (req) begin
      unique case (idx)
        // reserved bit reads one; weight in 5:0
        pwm_dac_pkg::IDX_WEIGHT0: next_st.rdata[7:0] =
          {1'b1, st.cfg[0].output_invert, st.cfg[0].weight};
        pwm_dac_pkg::IDX_WEIGHT1: next_st.rdata[7:0] =
          {1'b1, st.cfg[1].output_invert, st.cfg[1].weight};
        pwm_dac_pkg::IDX_WEIGHT2: next_st.rdata[7:0] =
          {1'b1, st.cfg[2].output_invert, st.cfg[2].weight};
        pwm_dac_pkg::IDX_WEIGHT3: next_st.rdata[7:0] =
          {1'b1, st.cfg[3].output_invert, st.cfg[3].weight};
        pwm_dac_pkg::IDX_RATE10:  next_st.rdata[7:0] =
          {st.rate_multiplier[1], st.rate_multiplier[0]};
        pwm_dac_pkg::IDX_RATE32:  next_st.rdata[7:0] =
          {st.rate_multiplier[3], st.rate_multiplier[2]};
        pwm_dac_pkg::IDX_COUNT:   next_st.rdata[9:0] = st.count;
        default:                  next_st.rdata = 32'h0000_0000;
      endcase
    end
    // writes touch only byte lane 0; other lanes are ignored
    if (wr) begin
      unique case (idx)
        pwm_dac_pkg::IDX_WEIGHT0: begin
          next_st.cfg[0].weight = wb_dat_i[5:0];
          next_st.cfg[0].output_invert = wb_dat_i[pwm_dac_pkg::INV_BIT];
        end
        pwm_dac_pkg::IDX_WEIGHT1: begin
          next_st.cfg[1].weight = wb_dat_i[5:0];
          next_st.cfg[1].output_invert = wb_dat_i[pwm_dac_pkg::INV_BIT];
        end
        pwm_dac_pkg::IDX_WEIGHT2: begin
          next_st.cfg[2].weight = wb_dat_i[5:0];
          next_st.cfg[2].output_invert = wb_dat_i[pwm_dac_pkg::INV_BIT];
        end
        pwm_dac_pkg::IDX_WEIGHT3: begin
          next_st.cfg[3].weight = wb_dat_i[5:0];
          next_st.cfg[3].output_invert = wb_dat_i[pwm_dac_pkg::INV_BIT];
        end
        pwm_dac_pkg::IDX_RATE10: begin
          next_st.rate_multiplier[0] = wb_dat_i[3:0];
          next_st.rate_multiplier[1] = wb_dat_i[7:4];
        end
        pwm_dac_pkg::IDX_RATE32: begin
          next_st.rate_multiplier[2] = wb_dat_i[3:0];
          next_st.rate_multiplier[3] = wb_dat_i[7:4];
        end
        default: begin
        end
      endcase
    end
  end

  // state register; pins reset to driven low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign dac_out  = st.pin;

  // assertions
  // counter step
  count_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> st.count == $past(st.count) + 10'h001)
    else $error("counter did not advance by one");
  // start of normal pulse after wrap
  wrap_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (low_cnt == 6'h00 && st.cfg[0].weight > 6'h01 && $stable(st.cfg[0]))
    |=> st.pulse[0])
    else $error("pulse not started after wrap");
  match_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    (low_cnt == st.cfg[0].weight && low_cnt != 6'h00 && low_cnt != 6'h3E
     && low_cnt != 6'h3F && $stable(st.cfg[0]))
    |=> !st.pulse[0])
    else $error("pulse not ended on weight match");
  polarity_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 $stable(st.cfg[1]) |-> dac_out[1] ==
    (st.pulse[1] ^ st.cfg[1].output_invert))
    else $error("output polarity wrong");
  rsv_one_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == pwm_dac_pkg::IDX_WEIGHT2)
    |=> wb_dat_o[pwm_dac_pkg::RSV_BIT])
    else $error("reserved bit read as zero");
  period_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (period == 4'h0) |-> extend == 4'h0)
    else $error("period 0 extended");
  // odd periods selected by top bit
  odd_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.rate_multiplier[2][3] && period[0]) |-> extend[2])
    else $error("odd period not extended");
  idle_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cfg[3] == 7'h00 && st.rate_multiplier[3] == 4'h0
     && low_cnt == 6'h3E)
    ##1 (st.cfg[3] == 7'h00 && st.rate_multiplier[3] == 4'h0)
    |-> !dac_out[3])
    else $error("idle channel not low");
  // extension clock lies just before the wrap
  extend_slot_a: assert property (@(posedge ref_clk) disable iff (rst)
    (low_cnt == 6'h3E && extend[0])
    |=> st.pulse[0])
    else $error("extension clock missing");
  count_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    st.count == 10'h3FF |=> st.count == 10'h000)
    else $error("counter did not roll over");
  // counter readable on its own index
  count_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == pwm_dac_pkg::IDX_COUNT)
    |=> wb_dat_o[9:0] == $past(st.count))
    else $error("counter read back wrong");
  weight_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == pwm_dac_pkg::IDX_WEIGHT0)
    |=> wb_dat_o[5:0] == $past(st.cfg[0].weight))
    else $error("weight read back wrong");
  invert_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == pwm_dac_pkg::IDX_WEIGHT1)
    |=> wb_dat_o[pwm_dac_pkg::INV_BIT] == $past(st.cfg[1].output_invert))
    else $error("invert bit read back wrong");
  // write places weight and invert in their fields
  weight_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr && idx == pwm_dac_pkg::IDX_WEIGHT3)
    |=> st.cfg[3].weight == $past(wb_dat_i[5:0])
    && st.cfg[3].output_invert == $past(wb_dat_i[6]))
    else $error("weight write misplaced");
  // reserved bit reads one on channel 0 too
  rsv_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == pwm_dac_pkg::IDX_WEIGHT0)
    |=> wb_dat_o[pwm_dac_pkg::RSV_BIT])
    else $error("reserved bit read as zero");
  // unused upper lanes read zero
  high_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx != pwm_dac_pkg::IDX_COUNT)
    |=> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  rate_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == pwm_dac_pkg::IDX_RATE10)
    |=> wb_dat_o[7:0] == {$past(st.rate_multiplier[1]),
                          $past(st.rate_multiplier[0])})
    else $error("rate pair read wrong");
  rate_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr && idx == pwm_dac_pkg::IDX_RATE32)
    |=> st.rate_multiplier[3] == $past(wb_dat_i[7:4])
    && st.rate_multiplier[2] == $past(wb_dat_i[3:0]))
    else $error("rate pair write misplaced");
  // bus answer one cycle after the request
  ack_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  // unmapped slot reads zero
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (req && !wb_we_i && idx == 3'h7)
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped slot read not zero");
  // each multiplier bit picks its periods
  ext_eight_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.rate_multiplier[1][0] && period == 4'h8) |-> extend[1])
    else $error("period 8 not extended");
  ext_four_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.rate_multiplier[1][1] && period[2:0] == 3'h4)
    |-> extend[1])
    else $error("period 4 or 12 not extended");
  ext_two_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.rate_multiplier[1][2] && period[1:0] == 2'h2)
    |-> extend[1])
    else $error("period 2, 6, 10 or 14 not extended");
  no_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    st.rate_multiplier[0] == 4'h0 |-> extend[0] == 1'b0)
    else $error("extension without multiplier");
  // full weight and multiplier keep the last slot high outside period 0
  full_on_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cfg[1] == 7'h7E && st.rate_multiplier[1] == 4'hF
     && low_cnt == 6'h3E && period != 4'h0) |=> dac_out[1])
    else $error("full setting dropped outside period 0");
  // only period 0 loses its last slot
  zero_gap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cfg[1] == 7'h7E && st.rate_multiplier[1] == 4'hF
     && low_cnt == 6'h3E && period == 4'h0) |=> !dac_out[1])
    else $error("full setting has no gap in period 0");
  // zero settings with invert stay high
  const_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cfg[2] == 7'h01 && st.rate_multiplier[2] == 4'h0
     && low_cnt == 6'h3E)
    ##1 (st.cfg[2] == 7'h01 && st.rate_multiplier[2] == 4'h0)
    |-> dac_out[2])
    else $error("inverted idle channel not high");
  // nonzero weight starts the pulse at the wrap
  start_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (low_cnt == 6'h3F && st.cfg[3].weight != 6'h00)
    |=> st.pulse[3])
    else $error("pulse not started at wrap");
  // pulse already low in the slot equal to the weight
  match_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cfg[2].weight != 6'h00 && st.cfg[2].weight != 6'h3F
     && low_cnt == st.cfg[2].weight && $stable(st.cfg[2]))
    |-> !st.pulse[2])
    else $error("pulse still high at weight slot");
  reset_low_a: assert property (@(posedge ref_clk)
    rst |-> dac_out == 4'h0)
    else $error("output not low during reset");

  rate_used_c: cover property (@(posedge ref_clk) disable iff (rst)
    extend[0] && low_cnt == 6'h3F);
  invert_hi_c: cover property (@(posedge ref_clk) disable iff (rst)
    st.cfg[1].output_invert && dac_out[1]);
  bus_write_c: cover property (@(posedge ref_clk) disable iff (rst)
    wr && idx == pwm_dac_pkg::IDX_RATE32);
  gap_zero_c: cover property (@(posedge ref_clk) disable iff (rst)
    st.rate_multiplier[1] == 4'hF && low_cnt == 6'h3E && period == 4'h0);
  const_high_c: cover property (@(posedge ref_clk) disable iff (rst)
    st.cfg[2] == 7'h01 && dac_out[2]);
endmodule : pwm_rate_multiplier_dac

// ---- dv/rc_filter_model.sv ----
// behavioural rc filter: high clocks of one pin summed per 1024-clock frame
`timescale 1ns/100ps
module rc_filter_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        pin,
  output logic      [10:0] level,
  output logic             frame_done
);
  logic [9:0]  cnt;
  logic [10:0] acc;

  // a full frame is needed: shorter windows miss the one-clock extensions
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      acc <= '0;
      level <= '0;
      frame_done <= 1'b0;
    end else begin
      cnt <= cnt + 10'h001;
      frame_done <= (cnt == 10'h3FF);
      if (cnt == 10'h3FF) begin
        level <= acc + 11'(pin);
        acc <= '0;
      end else begin
        acc <= acc + 11'(pin);
      end
    end
  end
endmodule : rc_filter_model

// ---- dv/pwm_rate_multiplier_dac_bench.sv ----
// self-checking bench: register access and filtered channel levels
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pwm_rate_multiplier_dac_bench;
  logic             ref_clk, rst, cyc, stb, we, ack;
  logic [4:0]       adr;
  logic [3:0]       sel, dac_out, done;
  logic [31:0]      dat_w, dat_r;
  logic [3:0][10:0] level;
  logic [7:0]       exp_q[$];
  logic [10:0]      exp_lvl;
  int               err_count, checks_done, seed = 32'h0CADBF2F;
  logic [5:0]       w[4];
  logic [3:0]       r[4];
  logic             inv[4];
  logic [2:0]       widx[4] = '{pwm_dac_pkg::IDX_WEIGHT0,
    pwm_dac_pkg::IDX_WEIGHT1, pwm_dac_pkg::IDX_WEIGHT2,
    pwm_dac_pkg::IDX_WEIGHT3};

  pwm_rate_multiplier_dac pwm_rate_multiplier_dac_i (.ref_clk(ref_clk),
    .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .dac_out(dac_out));

  // one filter per channel pin
  for (genvar c = 0; c < 4; c++) begin : filt
    rc_filter_model rc_filter_model_i (.ref_clk(ref_clk), .rst(rst),
      .pin(dac_out[c]), .level(level[c]), .frame_done(done[c]));
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // read data is compared with the oldest noted value at the ack edge
  always @(posedge ref_clk) begin
    if (ack === 1'b1 && we === 1'b0) `CHK(dat_r, {24'h0, exp_q.pop_front()})
  end

  task stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // classic cycle: hold everything until ack is seen high
  task automatic wb(input logic w_en, input logic [2:0] idx,
                    input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= {idx, 2'b00};
    sel <= 4'h1 | 4'($random(seed));
    dat_w <= {24'($random(seed)), d};
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [2:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    wb(1'b0, idx, 8'h00);
  endtask : rd

  // waits for frame ends, bounded so a dead filter cannot hang the run
  task automatic frames(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (done[0] !== 1'b1 && n < 1100);
      if (n >= 1100) begin
        err_count++;
        stop_test();
      end
    end
  endtask : frames

  initial begin
    {rst, cyc, stb, we, adr, sel, dat_w} = {1'b1, 44'h0};
    repeat (2) @(posedge ref_clk);
    `CHK(dac_out, 4'h0)
    rst <= 1'b0;
    // reset values, then a write to the unmapped slot must not stick
    for (int i = 0; i < 6; i++)
      rd(i[2:0], (i == 1 || i == 4) ? 8'h00 : 8'h80);
    wb(1'b1, 3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    // first pass fixed corner cases, later passes walk each multiplier bit
    for (int it = 0; it < 5; it++) begin
      for (int c = 0; c < 4; c++) begin
        w[c] = 6'($random(seed));
        r[c] = 4'($random(seed));
        inv[c] = 1'($random(seed));
      end
      if (it == 0) begin
        w = '{6'h00, 6'h3F, 6'h00, 6'h18};
        r = '{4'h0, 4'hF, 4'h0, 4'h6};
        inv = '{1'b0, 1'b0, 1'b1, 1'b0};
      end else r[0] = 4'h1 << (it - 1);
      for (int c = 0; c < 4; c++)
        wb(1'b1, widx[c], {1'($random(seed)), inv[c], w[c]});
      wb(1'b1, pwm_dac_pkg::IDX_RATE10, {r[1], r[0]});
      wb(1'b1, pwm_dac_pkg::IDX_RATE32, {r[3], r[2]});
      for (int c = 0; c < 4; c++) rd(widx[c], {1'b1, inv[c], w[c]});
      rd(pwm_dac_pkg::IDX_RATE10, {r[1], r[0]});
      rd(pwm_dac_pkg::IDX_RATE32, {r[3], r[2]});
      frames(2);
      // high clocks per frame are sixteen times the weight plus the rate
      for (int c = 0; c < 4; c++) begin
        exp_lvl = {1'b0, w[c], r[c]};
        if (inv[c]) exp_lvl = 11'h400 - exp_lvl;
        `CHK(level[c], exp_lvl)
      end
    end
    stop_test();
  end
endmodule : pwm_rate_multiplier_dac_bench
